// *** hdl/trms_chan_out.sv ***
// one serial output lane: channel framing, byte choice and drive control
`timescale 1ns/1ps
`include "trms_consts.svh"

module trms_chan_out (
   // link clock and reset
   input  wire logic       i_master_clock_in,
   input  wire logic       i_rst_n,
   // frame timing and stream setup
   input  wire logic       i_frame_start,
   input  wire logic       i_st_style,
   input  wire logic [2:0] i_rate,
   input  wire logic       i_used,
   // connection memory word and data memory bytes of the next channel
   input  wire logic       i_msg_mode_bit,
   input  wire logic       i_output_drive_bit,
   input  wire logic       i_source_select,
   input  wire logic [7:0] i_msg_byte,
   input  wire logic [7:0] i_local_byte,
   input  wire logic [7:0] i_bp_byte,
   // serial lane
   output logic            o_serial_out,
   output logic            o_serial_oe,
   output logic [8:0]      o_chan_index,
   output logic            o_chan_load
);

   trms_pkg::trms_chan_type s_r;
   trms_pkg::trms_chan_type s_nxt;

   function automatic logic [8:0] last_chan(input logic [2:0] rate);
      last_chan = 9'((`TRMS_MIN_CHANS << rate) - 10'h001);
   endfunction

   always_comb begin
      logic [7:0] byte_v;
      logic [3:0] div_last;
      logic       load_v;
      byte_v   = i_msg_mode_bit ? i_msg_byte : (i_source_select ? i_bp_byte : i_local_byte);
      div_last = 4'((`TRMS_BIT_SPAN >> i_rate) - 5'h01);
      load_v   = 1'b0;
      s_nxt      = s_r;
      s_nxt.load = 1'b0;
      if (i_frame_start) begin
         s_nxt.phase   = trms_pkg::TRMS_RUN;
         s_nxt.chan    = 9'h000;
         s_nxt.div     = 4'h0;
         s_nxt.bit_idx = 3'h0;
         load_v        = 1'b1;
      end else if (s_r.phase == trms_pkg::TRMS_RUN) begin
         if (s_r.div == div_last) begin
            s_nxt.div = 4'h0;
            if (s_r.bit_idx == `TRMS_LAST_BIT) begin
               s_nxt.bit_idx = 3'h0;
               s_nxt.chan    = (s_r.chan == last_chan(i_rate)) ? 9'h000 : s_r.chan + 9'h001;
               load_v        = 1'b1;
            end else begin
               s_nxt.bit_idx = s_r.bit_idx + 3'h1;
               if (i_st_style) begin
                  s_nxt.shreg = {s_r.shreg[6:0], 1'b0};
                  s_nxt.ser   = s_r.shreg[6];
               end else begin
                  s_nxt.shreg = {1'b0, s_r.shreg[7:1]};
                  s_nxt.ser   = s_r.shreg[1];
               end
            end
         end else begin
            s_nxt.div = s_r.div + 4'h1;
         end
      end
      if (load_v) begin
         s_nxt.shreg = byte_v;
         s_nxt.ser   = i_st_style ? byte_v[7] : byte_v[0];
         s_nxt.oe    = i_output_drive_bit & i_used;
         s_nxt.load  = 1'b1;
      end
   end

   always_ff @(posedge i_master_clock_in or negedge i_rst_n) begin
      if (!i_rst_n) begin
         s_r <= '0;
      end else begin
         s_r <= s_nxt;
      end
   end

   assign o_serial_out = s_r.ser;
   assign o_serial_oe  = s_r.oe;
   assign o_chan_index = s_r.chan;
   assign o_chan_load  = s_r.load;

   drive_ctl_a: assert property (@(posedge i_master_clock_in) disable iff (!i_rst_n)
      i_frame_start |=> (o_serial_oe == $past(i_output_drive_bit & i_used)))
      else $error("lane drive does not follow drive bit");

   msg_first_a: assert property (@(posedge i_master_clock_in) disable iff (!i_rst_n)
      (i_frame_start && i_msg_mode_bit && i_st_style) |=> (o_serial_out == $past(i_msg_byte[7])))
      else $error("message byte not sent msb first");

endmodule

// *** hdl/trms_consts.svh ***
// timing counts, codes and sizes for the tdm rate and mode selection block
`ifndef TRMS_CONSTS_SVH
`define TRMS_CONSTS_SVH

`define TRMS_BP_STREAMS      32
`define TRMS_LOCAL_STREAMS   16
`define TRMS_BP_FAST_STREAMS 16

`define TRMS_RATE_2M  3'h0
`define TRMS_RATE_4M  3'h1
`define TRMS_RATE_8M  3'h2
`define TRMS_RATE_16M 3'h3
`define TRMS_RATE_32M 3'h4

`define TRMS_FAST_RESET 1'b0
`define TRMS_MIN_CHANS  10'h020
`define TRMS_BIT_SPAN   5'h10
`define TRMS_LAST_BIT   3'h7

`define TRMS_MCLK_NS      160
`define TRMS_IDLE_NS      1200
`define TRMS_IDLE_RUN     (4'((`TRMS_IDLE_NS + `TRMS_MCLK_NS - 1) / `TRMS_MCLK_NS))

`endif

// *** hdl/trms_frame_detect.sv ***
// master frame pulse style detection and frame boundary marking
`timescale 1ns/1ps
`include "trms_consts.svh"

module trms_frame_detect (
   // link clock and reset
   input  wire logic i_master_clock_in,
   input  wire logic i_rst_n,
   // master frame pulse pin
   input  wire logic i_master_frame_pulse_in,
   // frame status
   output logic      o_frame_start,
   output logic      o_st_style,
   output logic      o_frame_tog
);

   trms_pkg::trms_detect_type s_r;
   trms_pkg::trms_detect_type s_nxt;

   // the idle level is the one that lasts; st-bus idles high, gci idles low
   always_comb begin
      s_nxt       = s_r;
      s_nxt.s1    = i_master_frame_pulse_in;
      s_nxt.s2    = s_r.s1;
      s_nxt.prev  = s_r.s2;
      s_nxt.start = 1'b0;
      if (s_r.s2 != s_r.prev) begin
         s_nxt.run = 4'h0;
      end else if (s_r.run != 4'hf) begin
         s_nxt.run = s_r.run + 4'h1;
      end
      if (s_r.s2 == s_r.prev && s_r.run >= `TRMS_IDLE_RUN) begin
         s_nxt.idle_hi = s_r.s2;
         s_nxt.known   = 1'b1;
      end
      if (s_r.known && s_r.prev == s_r.idle_hi && s_r.s2 != s_r.idle_hi) begin
         s_nxt.start = 1'b1;
         s_nxt.tog   = ~s_r.tog;
      end
   end

   always_ff @(posedge i_master_clock_in or negedge i_rst_n) begin
      if (!i_rst_n) begin
         s_r <= '0;
      end else begin
         s_r <= s_nxt;
      end
   end

   assign o_frame_start = s_r.start;
   assign o_st_style    = s_r.idle_hi;
   assign o_frame_tog   = s_r.tog;

   style_track_a: assert property (@(posedge i_master_clock_in) disable iff (!i_rst_n)
      (s_r.known && s_r.s2 == s_r.prev && s_r.run >= `TRMS_IDLE_RUN) |=> (o_st_style == $past(s_r.s2)))
      else $error("frame style not taken from idle level");

endmodule

// *** hdl/trms_pkg.sv ***
// types shared by the tdm rate and mode selection block
package trms_pkg;

   typedef logic [2:0] trms_rate_type;

   typedef enum logic {TRMS_WAIT, TRMS_RUN} trms_phase_type;

   typedef struct packed {
      logic       s1;
      logic       s2;
      logic       prev;
      logic [3:0] run;
      logic       idle_hi;
      logic       known;
      logic       start;
      logic       tog;
   } trms_detect_type;

   typedef struct packed {
      trms_phase_type phase;
      logic [3:0]     div;
      logic [2:0]     bit_idx;
      logic [8:0]     chan;
      logic [7:0]     shreg;
      logic           ser;
      logic           oe;
      logic           load;
   } trms_chan_type;

endpackage

// *** hdl/trms_top.sv ***
// per-stream rate and backplane mode selection with serial lane framing
`timescale 1ns/1ps
`include "trms_consts.svh"

// Function
// - each local output stream rate from register
// - local message bit picks message or connection
// - local drive bit drives or floats channel
// - local source bit picks data memory
// - fast backplane bit selects 32 Mb/s mode
// - fast backplane bit cleared by reset
// - local rates unaffected by backplane mode
// - slow mode: every stream picks 2-16 Mb/s
// - fast mode: backplane streams 0-15 at 32 Mb/s
// - fast mode: backplane streams 16-31 unused
// - slow mode: backplane input rate from register
// - fast mode ignores backplane input rate registers
// - slow mode: backplane output rate from register
// - fast mode ignores backplane output rate registers
// - backplane message bit picks message or connection
// - backplane drive bit drives or floats channel
// - backplane source bit picks data memory
// - frame pulse style detected automatically
module trms_top (
   // system clock and reset
   input  wire logic        i_clock,
   input  wire logic        i_rst_n,
   // link clock and frame pulse
   input  wire logic        i_master_clock_in,
   input  wire logic        i_master_frame_pulse_in,
   // mode and rate setup
   input  wire logic        i_fast_backplane_select,
   input  wire logic [31:0] i_local_out_rate_regs,
   input  wire logic [63:0] i_bp_in_rate_regs,
   input  wire logic [63:0] i_bp_out_rate_regs,
   // lane stream choice
   input  wire logic [3:0]  i_local_lane_stream,
   input  wire logic [4:0]  i_bp_lane_stream,
   // local connection memory word, link clock timed
   input  wire logic        i_local_msg_mode_bit,
   input  wire logic        i_local_output_drive_bit,
   input  wire logic        i_local_source_select,
   input  wire logic [7:0]  i_local_msg_byte,
   // backplane connection memory word, link clock timed
   input  wire logic        i_bp_msg_mode_bit,
   input  wire logic        i_bp_output_drive_bit,
   input  wire logic        i_bp_source_select,
   input  wire logic [7:0]  i_bp_msg_byte,
   // data memory bytes, link clock timed
   input  wire logic [7:0]  i_local_mem_byte,
   input  wire logic [7:0]  i_bp_mem_byte,
   // effective stream rates and use
   output logic             o_fast_backplane,
   output logic [47:0]      o_local_out_rate,
   output logic [95:0]      o_bp_in_rate,
   output logic [95:0]      o_bp_out_rate,
   output logic [31:0]      o_bp_in_used,
   output logic [31:0]      o_bp_out_used,
   // frame status in system clock domain
   output logic             o_st_style,
   output logic             o_frame_seen,
   // serial lanes, link clock timed
   output logic             o_local_serial_out,
   output logic             o_local_serial_oe,
   output logic [8:0]       o_local_chan_index,
   output logic             o_local_chan_load,
   output logic             o_bp_serial_out,
   output logic             o_bp_serial_oe,
   output logic [8:0]       o_bp_chan_index,
   output logic             o_bp_chan_load
);

   ////////////////////////////////////////////////////////////////////////////
   // system domain state

   typedef struct packed {
      logic        fast;
      logic [47:0] local_rate;
      logic [95:0] bp_in_rate;
      logic [95:0] bp_out_rate;
      logic [31:0] bp_in_used;
      logic [31:0] bp_out_used;
      logic        style_s1;
      logic        style_s2;
      logic        tog_s1;
      logic        tog_s2;
      logic        tog_s3;
      logic        seen;
   } trms_sys_type;

   typedef struct packed {
      logic [2:0] lrate_s1;
      logic [2:0] lrate_s2;
      logic [2:0] brate_s1;
      logic [2:0] brate_s2;
      logic       bused_s1;
      logic       bused_s2;
   } trms_link_type;

   trms_sys_type  sys_r;
   trms_sys_type  sys_nxt;
   trms_link_type lnk_r;
   trms_link_type lnk_nxt;

   logic          frame_start;
   logic          st_style_link;
   logic          frame_tog_link;

   // backplane stream rate: fixed in fast mode for the low half, unused above
   function automatic trms_pkg::trms_rate_type bp_rate(input logic fast, input int unsigned idx,
                                                       input logic [1:0] reg_rate);
      if (fast) begin
         bp_rate = (idx < `TRMS_BP_FAST_STREAMS) ? `TRMS_RATE_32M : `TRMS_RATE_2M;
      end else begin
         bp_rate = {1'b0, reg_rate};
      end
   endfunction

   function automatic logic bp_used(input logic fast, input int unsigned idx);
      bp_used = !fast || (idx < `TRMS_BP_FAST_STREAMS);
   endfunction

   always_comb begin
      sys_nxt          = sys_r;
      sys_nxt.fast     = i_fast_backplane_select;
      sys_nxt.style_s1 = st_style_link;
      sys_nxt.style_s2 = sys_r.style_s1;
      sys_nxt.tog_s1   = frame_tog_link;
      sys_nxt.tog_s2   = sys_r.tog_s1;
      sys_nxt.tog_s3   = sys_r.tog_s2;
      sys_nxt.seen     = sys_r.tog_s2 ^ sys_r.tog_s3;
      for (int i = 0; i < `TRMS_LOCAL_STREAMS; i++) begin
         sys_nxt.local_rate[i*3 +: 3] = {1'b0, i_local_out_rate_regs[i*2 +: 2]};
      end
      for (int i = 0; i < `TRMS_BP_STREAMS; i++) begin
         sys_nxt.bp_in_rate[i*3 +: 3]  = bp_rate(sys_r.fast, i, i_bp_in_rate_regs[i*2 +: 2]);
         sys_nxt.bp_out_rate[i*3 +: 3] = bp_rate(sys_r.fast, i, i_bp_out_rate_regs[i*2 +: 2]);
         sys_nxt.bp_in_used[i]         = bp_used(sys_r.fast, i);
         sys_nxt.bp_out_used[i]        = bp_used(sys_r.fast, i);
      end
   end

   always_ff @(posedge i_clock or negedge i_rst_n) begin
      if (!i_rst_n) begin
         sys_r             <= '0;
         sys_r.fast        <= `TRMS_FAST_RESET;
         sys_r.bp_in_used  <= '1;
         sys_r.bp_out_used <= '1;
      end else begin
         sys_r <= sys_nxt;
      end
   end

   assign o_fast_backplane = sys_r.fast;
   assign o_local_out_rate = sys_r.local_rate;
   assign o_bp_in_rate     = sys_r.bp_in_rate;
   assign o_bp_out_rate    = sys_r.bp_out_rate;
   assign o_bp_in_used     = sys_r.bp_in_used;
   assign o_bp_out_used    = sys_r.bp_out_used;
   assign o_st_style       = sys_r.style_s2;
   assign o_frame_seen     = sys_r.seen;

   ////////////////////////////////////////////////////////////////////////////
   // link domain: rates of the lane streams cross as quasi-static levels

   always_comb begin
      lnk_nxt          = lnk_r;
      lnk_nxt.lrate_s1 = sys_r.local_rate[i_local_lane_stream*3 +: 3];
      lnk_nxt.lrate_s2 = lnk_r.lrate_s1;
      lnk_nxt.brate_s1 = sys_r.bp_out_rate[i_bp_lane_stream*3 +: 3];
      lnk_nxt.brate_s2 = lnk_r.brate_s1;
      lnk_nxt.bused_s1 = sys_r.bp_out_used[i_bp_lane_stream];
      lnk_nxt.bused_s2 = lnk_r.bused_s1;
   end

   always_ff @(posedge i_master_clock_in or negedge i_rst_n) begin
      if (!i_rst_n) begin
         lnk_r <= '0;
      end else begin
         lnk_r <= lnk_nxt;
      end
   end

   trms_frame_detect u_detect (
      .i_master_clock_in      (i_master_clock_in),
      .i_rst_n                (i_rst_n),
      .i_master_frame_pulse_in(i_master_frame_pulse_in),
      .o_frame_start          (frame_start),
      .o_st_style             (st_style_link),
      .o_frame_tog            (frame_tog_link)
   );

   trms_chan_out u_local_lane (
      .i_master_clock_in (i_master_clock_in),
      .i_rst_n           (i_rst_n),
      .i_frame_start     (frame_start),
      .i_st_style        (st_style_link),
      .i_rate            (lnk_r.lrate_s2),
      .i_used            (1'b1),
      .i_msg_mode_bit    (i_local_msg_mode_bit),
      .i_output_drive_bit(i_local_output_drive_bit),
      .i_source_select   (i_local_source_select),
      .i_msg_byte        (i_local_msg_byte),
      .i_local_byte      (i_local_mem_byte),
      .i_bp_byte         (i_bp_mem_byte),
      .o_serial_out      (o_local_serial_out),
      .o_serial_oe       (o_local_serial_oe),
      .o_chan_index      (o_local_chan_index),
      .o_chan_load       (o_local_chan_load)
   );

   trms_chan_out u_bp_lane (
      .i_master_clock_in (i_master_clock_in),
      .i_rst_n           (i_rst_n),
      .i_frame_start     (frame_start),
      .i_st_style        (st_style_link),
      .i_rate            (lnk_r.brate_s2),
      .i_used            (lnk_r.bused_s2),
      .i_msg_mode_bit    (i_bp_msg_mode_bit),
      .i_output_drive_bit(i_bp_output_drive_bit),
      .i_source_select   (i_bp_source_select),
      .i_msg_byte        (i_bp_msg_byte),
      .i_local_byte      (i_local_mem_byte),
      .i_bp_byte         (i_bp_mem_byte),
      .o_serial_out      (o_bp_serial_out),
      .o_serial_oe       (o_bp_serial_oe),
      .o_chan_index      (o_bp_chan_index),
      .o_chan_load       (o_bp_chan_load)
   );

   ////////////////////////////////////////////////////////////////////////////
   // checks

   fast_reset_a: assert property (@(posedge i_clock)
      $rose(i_rst_n) |-> !o_fast_backplane)
      else $error("fast backplane mode not clear after reset");

   mode_select_a: assert property (@(posedge i_clock) disable iff (!i_rst_n)
      i_fast_backplane_select ##1 i_fast_backplane_select |-> o_fast_backplane ##1 o_bp_in_rate[2:0] == 3'h4)
      else $error("fast mode not entered");

   bp_fast_rate_a: assert property (@(posedge i_clock) disable iff (!i_rst_n)
      o_fast_backplane |=> (o_bp_in_rate[47:45] == 3'h4 && o_bp_out_rate[2:0] == 3'h4))
      else $error("low backplane streams not at 32 Mb/s");

   bp_upper_off_a: assert property (@(posedge i_clock) disable iff (!i_rst_n)
      o_fast_backplane |=> (!o_bp_in_used[16] && !o_bp_out_used[31] && o_bp_in_used[15]))
      else $error("upper backplane streams still used");

   bp_in_follow_a: assert property (@(posedge i_clock) disable iff (!i_rst_n)
      !o_fast_backplane |=> (o_bp_in_rate[95:93] == {1'b0, $past(i_bp_in_rate_regs[63:62])}))
      else $error("backplane input rate not taken");

   bp_in_ignore_a: assert property (@(posedge i_clock) disable iff (!i_rst_n)
      o_fast_backplane [*3] |-> $stable(o_bp_in_rate))
      else $error("backplane input rate moved in fast mode");

   bp_out_follow_a: assert property (@(posedge i_clock) disable iff (!i_rst_n)
      !o_fast_backplane |=> (o_bp_out_rate[5:3] == {1'b0, $past(i_bp_out_rate_regs[3:2])}))
      else $error("backplane output rate not taken");

   bp_out_ignore_a: assert property (@(posedge i_clock) disable iff (!i_rst_n)
      o_fast_backplane [*3] |-> $stable(o_bp_out_rate))
      else $error("backplane output rate moved in fast mode");

   local_rate_a: assert property (@(posedge i_clock) disable iff (!i_rst_n)
      1'b1 |=> (o_local_out_rate[47:45] == {1'b0, $past(i_local_out_rate_regs[31:30])}))
      else $error("local output rate not taken");

endmodule

// *** verif/trms_tdm_peer.sv ***
// far-end tdm device: master frame pulse source and serial lane receiver
`timescale 1ns/1ps
module trms_tdm_peer #(
   parameter int FRAME_CLKS = 781
) (
   // link clock and reset
   input  wire logic       i_mclk,
   input  wire logic       i_rst_n,
   // framing and lane rate
   input  wire logic       i_st,
   input  wire logic       i_wide,
   input  wire logic [2:0] i_rate,
   // serial lane from the device
   input  wire logic       i_ser,
   input  wire logic       i_oe,
   input  wire logic       i_load,
   // frame pulse and last good byte
   output logic            o_fp,
   output logic [7:0]      o_byte,
   output logic            o_oe,
   output int              o_cnt
);
   int         ph = 0;
   int         fcnt = 0;
   int         f0;
   int         p0;
   logic       on = 1'b0;
   logic       oe0;
   logic [7:0] sh;
   initial o_cnt = 0;
   initial o_fp = 1'b1;
   ////////////////////////////////////////////////////////////
   // one pulse a frame, one or two link clocks wide, idle level by style
   always @(posedge i_mclk) begin
      #5;
      on = i_rst_n && (on || ph == FRAME_CLKS - 1);
      ph = (!i_rst_n || ph == FRAME_CLKS - 1) ? 0 : ph + 1;
      if (on && ph == 0)
         fcnt++;
      o_fp = i_st ^ (on && (ph == 0 || (i_wide && ph == 1)));
   end
   ////////////////////////////////////////////////////////////
   // byte capture, dropped when a frame restart may cut into it
   always begin
      @(negedge i_mclk iff (i_load === 1'b1));
      f0 = fcnt;
      p0 = ph;
      oe0 = i_oe;
      for (int i = 0; i < 8; i++) begin
         sh = {sh[6:0], i_ser};
         if (i < 7)
            repeat (16 >> i_rate) @(negedge i_mclk);
      end
      if (fcnt == f0 && p0 >= 8) begin
         o_byte = i_st ? sh : {<<{sh}};
         o_oe = oe0;
         o_cnt++;
      end
   end
endmodule

// *** verif/trms_top_bench.sv ***
// self-checking bench for the tdm port rate and mode selection block
`timescale 1ns/1ps
module trms_top_bench;
   typedef struct packed {
      logic        fast;
      logic [1:0]  k;
      logic [31:0] used;
   } trms_row_type;
   trms_row_type rows [8] = '{'{1'b0, 2'h0, 32'hffffffff}, '{1'b1, 2'h1, 32'h0000ffff},
      '{1'b1, 2'h2, 32'h0000ffff}, '{1'b0, 2'h3, 32'hffffffff}, '{1'b1, 2'h0, 32'h0000ffff},
      '{1'b0, 2'h1, 32'hffffffff}, '{1'b0, 2'h2, 32'hffffffff}, '{1'b1, 2'h3, 32'h0000ffff}};
   // {message, drive, source} per case
   logic [2:0]  cs [4] = '{3'b110, 3'b010, 3'b011, 3'b000};
   logic        clk = 1'b0;
   logic        mclk = 1'b0;
   logic        rst_n = 1'b0;
   logic        fast = 1'b0;
   logic        st = 1'b1;
   logic        wide = 1'b0;
   logic [31:0] lo_r = '0;
   logic [63:0] bi_r = '0;
   logic [63:0] bo_r = '0;
   logic [3:0]  l_str = 4'h7;
   logic [4:0]  b_str = 5'h09;
   logic [2:0]  lw = '0;
   logic [2:0]  bw = '0;
   logic [7:0]  lmsg = 8'hc1;
   logic [7:0]  bmsg = 8'h4e;
   logic [7:0]  lmem = 8'h3a;
   logic [7:0]  bmem = 8'h5d;
   logic [47:0] e_lo, lrate;
   logic [95:0] e_bi, e_bo, birate, borate;
   logic [31:0] biused, boused;
   logic [7:0]  el, eb, l_byte, b_byte;
   logic        fast_o, st_o, seen, l_ser, l_oe, l_ld, b_ser, b_oe, b_ld, fp, l_oer, b_oer, hi;
   int          l_cnt, b_cnt;
   int          num_errors = 0;
   int          n_tests = 0;
   int          cyc = 0;
   int          frames = 0;

   trms_top dut (.i_clock(clk), .i_rst_n(rst_n), .i_master_clock_in(mclk), .i_master_frame_pulse_in(fp),
      .i_fast_backplane_select(fast), .i_local_out_rate_regs(lo_r), .i_bp_in_rate_regs(bi_r),
      .i_bp_out_rate_regs(bo_r), .i_local_lane_stream(l_str), .i_bp_lane_stream(b_str),
      .i_local_msg_mode_bit(lw[2]), .i_local_output_drive_bit(lw[1]), .i_local_source_select(lw[0]),
      .i_local_msg_byte(lmsg), .i_bp_msg_mode_bit(bw[2]), .i_bp_output_drive_bit(bw[1]),
      .i_bp_source_select(bw[0]), .i_bp_msg_byte(bmsg), .i_local_mem_byte(lmem), .i_bp_mem_byte(bmem),
      .o_fast_backplane(fast_o), .o_local_out_rate(lrate), .o_bp_in_rate(birate), .o_bp_out_rate(borate),
      .o_bp_in_used(biused), .o_bp_out_used(boused), .o_st_style(st_o), .o_frame_seen(seen),
      .o_local_serial_out(l_ser), .o_local_serial_oe(l_oe), .o_local_chan_index(), .o_local_chan_load(l_ld),
      .o_bp_serial_out(b_ser), .o_bp_serial_oe(b_oe), .o_bp_chan_index(), .o_bp_chan_load(b_ld));
   trms_tdm_peer peer_l (.i_mclk(mclk), .i_rst_n(rst_n), .i_st(st), .i_wide(wide), .i_rate(3'h3),
      .i_ser(l_ser), .i_oe(l_oe), .i_load(l_ld), .o_fp(fp), .o_byte(l_byte), .o_oe(l_oer), .o_cnt(l_cnt));
   trms_tdm_peer peer_b (.i_mclk(mclk), .i_rst_n(rst_n), .i_st(st), .i_wide(wide), .i_rate(fast ? 3'h4 : 3'h2),
      .i_ser(b_ser), .i_oe(b_oe), .i_load(b_ld), .o_fp(), .o_byte(b_byte), .o_oe(b_oer), .o_cnt(b_cnt));

   always #50 clk = ~clk;
   always #80 mclk = ~mclk;
   always @(negedge clk)
      if (seen === 1'b1)
         frames++;
   always @(posedge clk) begin
      cyc++;
      if (cyc == 20000) begin
         num_errors++;
         tally_and_finish;
      end
   end
   ////////////////////////////////////////////////////////////
   task automatic chk(input string nm, input logic [95:0] exp, input logic [95:0] got);
      n_tests++;
      if (got !== exp) begin
         num_errors++;
         $display("[ERR] %s expected %h seen %h", nm, exp, got);
      end
   endtask

   task automatic tally_and_finish;
      $display("comparisons %0d mismatches %0d", n_tests, num_errors);
      if (num_errors == 0 && n_tests > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask

   task automatic wait_frame;
      int f0;
      f0 = frames;
      for (int i = 0; i < 4000 && frames == f0; i++)
         @(posedge clk);
      #5 chk("frame seen", 1'b1, frames > f0);
   endtask

   // two whole bytes on each lane, so the second used the new word
   task automatic wait_rx;
      int a;
      int b;
      a = l_cnt + 2;
      b = b_cnt + 2;
      for (int i = 0; i < 4000 && (l_cnt < a || b_cnt < b); i++)
         @(posedge clk);
      chk("lane bytes seen", 1'b1, l_cnt >= a && b_cnt >= b);
   endtask
   ////////////////////////////////////////////////////////////
   initial begin
      repeat (3) @(posedge clk);
      #5 chk("used in reset", {64{1'b1}}, {biused, boused});
      chk("fast in reset", 1'b0, fast_o);
      repeat (2) @(posedge clk);
      #5 rst_n = 1'b1;
      foreach (rows[r]) begin
         @(posedge clk);
         #5 fast = rows[r].fast;
         for (int n = 0; n < 32; n++) begin
            bi_r[2*n+:2] = 2'(n + rows[r].k);
            bo_r[2*n+:2] = 2'(n + rows[r].k + 1);
            e_bi[3*n+:3] = rows[r].fast ? (n < 16 ? 3'h4 : 3'h0) : {1'b0, bi_r[2*n+:2]};
            e_bo[3*n+:3] = rows[r].fast ? (n < 16 ? 3'h4 : 3'h0) : {1'b0, bo_r[2*n+:2]};
            if (n < 16) begin
               lo_r[2*n+:2] = 2'(3 * n + rows[r].k);
               e_lo[3*n+:3] = {1'b0, lo_r[2*n+:2]};
            end
         end
         repeat (2) @(posedge clk);
         #5 chk("fast mode", rows[r].fast, fast_o);
         chk("local rate", e_lo, lrate);
         chk("bp in rate", e_bi, birate);
         chk("bp out rate", e_bo, borate);
         chk("bp in used", rows[r].used, biused);
         chk("bp out used", rows[r].used, boused);
      end
      lo_r = {16{2'h3}};
      bi_r = {32{2'h2}};
      bo_r = {32{2'h2}};
      for (int p = 0; p < 2; p++) begin
         if (p == 1) begin
            @(posedge clk);
            #5 rst_n = 1'b0;
            fast = 1'b1;
            st = 1'b0;
            wide = 1'b1;
            b_str = 5'h03;
            repeat (5) @(posedge clk);
            #5 chk("fast after reset", 1'b0, fast_o);
            rst_n = 1'b1;
         end
         wait_frame;
         chk("frame style", st, st_o);
         for (int c = 0; c < 4; c++) begin
            @(posedge mclk);
            #5 lw = cs[c];
            bw = cs[(c + 2) % 4];
            el = lw[2] ? lmsg : (lw[0] ? bmem : lmem);
            eb = bw[2] ? bmsg : (bw[0] ? bmem : lmem);
            wait_rx;
            chk("local oe", lw[1], l_oer);
            if (lw[1])
               chk("local byte", el, l_byte);
            chk("bp oe", bw[1], b_oer);
            if (bw[1])
               chk("bp byte", eb, b_byte);
         end
      end
      // upper backplane stream in fast mode must never drive
      @(posedge clk);
      #5 b_str = 5'h14;
      bw = 3'b010;
      hi = 1'b0;
      // the byte in flight slows to the unused rate, so let it finish first
      repeat (150) @(negedge mclk);
      repeat (200) begin
         @(negedge mclk);
         hi = hi | b_oe;
      end
      chk("unused bp oe", 1'b0, hi);
      tally_and_finish;
   end
endmodule
